// >>> rtc_aux_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package only; the design files use its macros without including it
`ifndef RTC_AUX_DEFS_SVH
`define RTC_AUX_DEFS_SVH

`define ADDR_CTRL1        4'h0
`define ADDR_CTRL2        4'h1
`define ADDR_SQW_CTRL     4'hD

`define CTRL1_EXTERNAL_CLOCK_TEST    7
`define CTRL1_FREEZE      5
`define CTRL2_TIE         0
`define CTRL2_AIE         1
`define CTRL2_CDF         2
`define CTRL2_ALF         3
`define CTRL2_TP          4

`define CTRL1_RESET       8'h00
`define CTRL2_RESET       8'h00
`define SQW_CTRL_RESET    3'h0

`define OSC_HZ            32768
`define PULSE_HZ_8192     8192
`define PULSE_HZ_4096     4096
`define PULSE_HZ_128      128
`define PULSE_HZ_64       64
`define TICKS_8192        (`OSC_HZ / `PULSE_HZ_8192)
`define TICKS_4096        (`OSC_HZ / `PULSE_HZ_4096)
`define TICKS_128         (`OSC_HZ / `PULSE_HZ_128)
`define TICKS_64          (`OSC_HZ / `PULSE_HZ_64)

`define PRESCALER_STAGES  15
`define FREE_STAGES       2
`define TEST_DIV_BITS     6

`endif

// >>> rtc_aux_pkg.sv
// types shared by the timekeeping support logic
// assumes rtc_aux_defs.svh is on the include path
package rtc_aux_pkg;
    `include "rtc_aux_defs.svh"

    typedef struct packed {
        logic tp;
        logic cdf;
        logic alf;
        logic alarm_irq_enable;
        logic timer_irq_enable;
    } ctrl2_t;

    typedef struct packed {
        logic       external_clock_test;
        logic       freeze;
    } ctrl1_t;

    typedef struct packed {
        logic       wr;
        logic [3:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    typedef enum logic [1:0] {
        SRC_4096,
        SRC_64,
        SRC_1,
        SRC_1_60
    } timer_src_t;

    typedef enum {
        P_IDLE,
        P_ACTIVE
    } pulse_state_t;
endpackage

// >>> freeze_prescaler.sv
// binary divide chain advanced on each oscillator tick
// assumes tick is a one-cycle strobe per oscillator rising edge
`timescale 1ns/1ps
`default_nettype none

module freeze_prescaler #(
    parameter int STAGES = `PRESCALER_STAGES,
    parameter int FREE   = `FREE_STAGES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              tick,
    input  wire logic              freeze,
    output logic [STAGES-1:0]      q
);
    import rtc_aux_pkg::*;

    initial
    begin
        if (FREE < 1 || STAGES <= FREE)
            $error("freeze_prescaler: bad stage counts");
    end

    logic [STAGES-1:0] q_nxt;

    always_comb
    begin
        q_nxt = q;
        if (tick)
        begin
            // first stage runs straight from the oscillator
            // R21 oscillator clocks chain
            q_nxt = q + {{(STAGES-1){1'b0}}, 1'b1};
        end
        // R17 upper stages cleared and held at zero
        // R18 R19 low two stages keep counting
        if (freeze)
        begin
            q_nxt[STAGES-1:FREE] = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= q_nxt;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_low_run;
        freeze && $past(freeze) && tick |=> q[FREE-1:0] == $past(q[FREE-1:0]) + 1'b1;
    endproperty
    a_low_run: assert property (p_low_run) else $error("low stages stalled in freeze"); // R18

    property p_upper_held;
        freeze |=> q[STAGES-1:FREE] == '0;
    endproperty
    a_upper_held: assert property (p_upper_held) else $error("upper stages ran in freeze"); // R17
endmodule

`default_nettype wire

// >>> rtc_prescaler_square_wave_pin_irq.sv
// prescaler, square-wave output, external clock test mode and interrupt pin
// assumes all inputs synchronous to CLK; OSC_IN is the 32.768 kHz oscillator level
//
// Operation
// R1: timer interrupt reaches pin only when enabled
// R2: 4096 Hz pulse half period if n=1
// R3: 64 Hz pulse 1/128 or 1/64 s
// R4: loaded zero stops, no pulses
// R5: clearing countdown flag cuts pulse short
// R6: level mode releases pin when enable cleared
// R7: alarm enabled makes pin follow flag
// R8: clearing alarm flag releases pin immediately
// R9: frequency code decode, 111 holds low
// R10: output enabled at reset, low when off
// R11: divided outputs have equal high/low
// R12: freeze holds 4096 Hz and slower low
// R13: test mode makes pin input, 64 edges/second
// R14: freeze clears test divider and holds it
// R15: after freeze, first tick at 32 edges
// R16: test entry prescaler state unknown
// R17: freeze holds upper stages, no ticks
// R18: lowest two stages run during freeze
// R19: first tick 0.5 s after release
// R20: second on final stage rising edge
// R21: first stage clocked from oscillator
// R22: host sequences test mode, pulses counted
// R23: write zero clears flag, one keeps
// R24: three sources wired-OR onto pin
// R25: writes registered before use
`timescale 1ns/1ps
`default_nettype none

module rtc_prescaler_square_wave_pin_irq #(
    parameter int STAGES   = `PRESCALER_STAGES,
    parameter int TEST_DIV = `TEST_DIV_BITS
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        OSC_IN,
    input  wire logic        REG_WR,
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    output logic      [7:0]  REG_RDATA,
    input  wire logic        TIMER_EVENT,
    input  wire logic [7:0]  TIMER_N,
    input  wire rtc_aux_pkg::timer_src_t TIMER_SRC,
    input  wire logic        ALARM_EVENT,
    input  wire logic        MS_IRQ,
    input  wire logic        SQW_I,
    output logic             SQW_O,
    output logic             SQW_OE,
    output logic             INT_N,
    output logic             SECOND_TICK
);
    import rtc_aux_pkg::*;

    initial
    begin
        if (STAGES != `PRESCALER_STAGES || TEST_DIV < 2)
            $error("rtc_prescaler_square_wave_pin_irq: unsupported divider widths");
    end

    ////////////////////////////////////////////////////////////////////////
    // register port

    reg_wr_t      wr_r;
    ctrl1_t       ctrl1_r;
    ctrl2_t       ctrl2_r;
    logic [2:0]   sqw_sel_r;
    logic         cdf_set;
    logic         alf_set;
    logic         wr_ctrl2;

    // R25 writes registered first
    always_ff @(posedge CLK)
    begin
        if (RST)
            wr_r <= '0;
        else
            wr_r <= '{wr: REG_WR, addr: REG_ADDR, data: REG_WDATA};
    end

    assign wr_ctrl2 = wr_r.wr && wr_r.addr == `ADDR_CTRL2;
    // R4 zero count produces nothing
    assign cdf_set  = TIMER_EVENT && TIMER_N != 8'h00;
    assign alf_set  = ALARM_EVENT;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ctrl1_r <= '0;
        end
        else if (wr_r.wr && wr_r.addr == `ADDR_CTRL1)
        begin
            ctrl1_r.external_clock_test <= wr_r.data[`CTRL1_EXTERNAL_CLOCK_TEST];
            ctrl1_r.freeze              <= wr_r.data[`CTRL1_FREEZE];
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ctrl2_r <= '0;
        end
        else
        begin
            if (wr_ctrl2)
            begin
                ctrl2_r.timer_irq_enable <= wr_r.data[`CTRL2_TIE];
                ctrl2_r.alarm_irq_enable <= wr_r.data[`CTRL2_AIE];
                ctrl2_r.tp  <= wr_r.data[`CTRL2_TP];
            end
            // R23 flags AND with written value
            // set wins over a clear in the same cycle
            ctrl2_r.cdf <= cdf_set || (ctrl2_r.cdf && !(wr_ctrl2 && !wr_r.data[`CTRL2_CDF]));
            ctrl2_r.alf <= alf_set || (ctrl2_r.alf && !(wr_ctrl2 && !wr_r.data[`CTRL2_ALF]));
        end
    end

    // R10 default selection drives the oscillator out
    always_ff @(posedge CLK)
    begin
        if (RST)
            sqw_sel_r <= `SQW_CTRL_RESET;
        else if (wr_r.wr && wr_r.addr == `ADDR_SQW_CTRL)
            sqw_sel_r <= wr_r.data[2:0];
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            REG_RDATA <= 8'h00;
        else
        begin
            unique case (REG_ADDR)
                `ADDR_CTRL1:    REG_RDATA <= {ctrl1_r.external_clock_test, 1'b0, ctrl1_r.freeze, 5'h00};
                `ADDR_CTRL2:    REG_RDATA <= {3'h0, ctrl2_r.tp, ctrl2_r.alf, ctrl2_r.cdf,
                                              ctrl2_r.alarm_irq_enable, ctrl2_r.timer_irq_enable};
                `ADDR_SQW_CTRL: REG_RDATA <= {5'h00, sqw_sel_r};
                default:        REG_RDATA <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator prescaler and seconds

    logic              osc_r;
    logic              osc_d_r;
    logic              osc_tick;
    logic [STAGES-1:0] pre_q;
    logic              top_d_r;
    logic              sqw_in_d_r;
    logic [TEST_DIV-1:0] tdiv_r;
    logic              tdiv_top_d_r;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            osc_r   <= 1'b0;
            osc_d_r <= 1'b0;
        end
        else
        begin
            osc_r   <= OSC_IN;
            osc_d_r <= osc_r;
        end
    end

    assign osc_tick = osc_r && !osc_d_r;

    freeze_prescaler #(
        .STAGES (STAGES),
        .FREE   (`FREE_STAGES)
    ) u_pre (
        .clk    (CLK),
        .rst    (RST),
        .tick   (osc_tick),
        .freeze (ctrl1_r.freeze),
        .q      (pre_q)
    );

    // R14 freeze clears test divider
    // R16 no clear on test entry
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sqw_in_d_r <= 1'b1;
            tdiv_r     <= '0;
        end
        else
        begin
            sqw_in_d_r <= SQW_I;
            if (ctrl1_r.freeze)
                tdiv_r <= '0;
            else if (ctrl1_r.external_clock_test && SQW_I && !sqw_in_d_r)
                tdiv_r <= tdiv_r + {{(TEST_DIV-1){1'b0}}, 1'b1};
        end
    end

    // R20 second on top stage rising
    // R15 top test bit first rises after 32 edges
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            top_d_r      <= 1'b0;
            tdiv_top_d_r <= 1'b0;
            SECOND_TICK  <= 1'b0;
        end
        else
        begin
            top_d_r      <= pre_q[STAGES-1];
            tdiv_top_d_r <= tdiv_r[TEST_DIV-1];
            // R13 test pin replaces oscillator
            if (ctrl1_r.external_clock_test)
                SECOND_TICK <= tdiv_r[TEST_DIV-1] && !tdiv_top_d_r;
            else
                SECOND_TICK <= pre_q[STAGES-1] && !top_d_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // square-wave output

    function automatic logic sqw_level(input logic [2:0] sel, input logic osc,
                                       input logic [STAGES-1:0] q);
        // R9 frequency decode
        // R11 divided taps are exact halves
        unique case (sel)
            3'h0:    sqw_level = osc;
            3'h1:    sqw_level = q[0];
            3'h2:    sqw_level = q[1];
            3'h3:    sqw_level = q[2];
            3'h4:    sqw_level = q[3];
            3'h5:    sqw_level = q[4];
            3'h6:    sqw_level = q[STAGES-1];
            default: sqw_level = 1'b0;
        endcase
    endfunction

    // open drain: enable means pulling low
    // R12 frozen taps read zero, so pin stays low
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            SQW_O  <= 1'b0;
            SQW_OE <= 1'b0;
        end
        else
        begin
            SQW_O  <= 1'b0;
            // R13 test mode releases the pin
            SQW_OE <= !ctrl1_r.external_clock_test && !sqw_level(sqw_sel_r, osc_r, pre_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // countdown pulse and interrupt pin

    pulse_state_t pst_r;
    logic [9:0]   pcnt_r;
    logic         pulse_act;
    logic         timer_irq;

    function automatic logic [9:0] pulse_ticks(input timer_src_t src, input logic n_one);
        unique case (src)
            // R2 4096 Hz source widths
            SRC_4096: pulse_ticks = n_one ? 10'(`TICKS_8192) : 10'(`TICKS_4096);
            // R3 64 Hz source widths
            SRC_64:   pulse_ticks = n_one ? 10'(`TICKS_128) : 10'(`TICKS_64);
            SRC_1,
            SRC_1_60: pulse_ticks = 10'(`TICKS_64);
        endcase
    endfunction

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pst_r  <= P_IDLE;
            pcnt_r <= 10'h000;
        end
        else
        begin
            unique case (pst_r)
                P_IDLE:
                begin
                    if (cdf_set)
                    begin
                        pst_r  <= P_ACTIVE;
                        pcnt_r <= pulse_ticks(TIMER_SRC, TIMER_N == 8'h01);
                    end
                end
                P_ACTIVE:
                begin
                    // R5 cleared flag ends pulse
                    if (!ctrl2_r.cdf)
                        pst_r <= P_IDLE;
                    else if (osc_tick)
                    begin
                        pcnt_r <= pcnt_r - 10'h001;
                        if (pcnt_r == 10'h001)
                            pst_r <= P_IDLE;
                    end
                end
            endcase
        end
    end

    assign pulse_act = pst_r == P_ACTIVE;
    // R1 R5 enable and flag gate timer source
    // R6 level mode follows enable and flag
    assign timer_irq = ctrl2_r.timer_irq_enable && ctrl2_r.cdf && (ctrl2_r.tp ? pulse_act : 1'b1);

    // R24 wired-OR of three sources
    // R7 R8 alarm follows flag level
    always_ff @(posedge CLK)
    begin
        if (RST)
            INT_N <= 1'b1;
        else
            INT_N <= !(timer_irq || (ctrl2_r.alarm_irq_enable && ctrl2_r.alf) || MS_IRQ);
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    logic [9:0] h_width_r;
    logic [9:0] h_len_r;

    always_ff @(posedge CLK)
    begin
        if (RST || !pulse_act)
            h_len_r <= 10'h000;
        else if (osc_tick)
            h_len_r <= h_len_r + 10'h001;
        if (RST)
            h_width_r <= 10'h000;
        else if (!pulse_act && cdf_set)
            h_width_r <= pulse_ticks(TIMER_SRC, TIMER_N == 8'h01);
    end

    sequence s_alarm_cleared;
        ctrl2_r.alarm_irq_enable && ctrl2_r.alf ##1 !ctrl2_r.alf && !timer_irq && !MS_IRQ;
    endsequence

    sequence s_frozen_slow;
        ctrl1_r.freeze && !ctrl1_r.external_clock_test && sqw_sel_r >= 3'h3;
    endsequence

    property p_width;
        pulse_act && ctrl2_r.cdf && osc_tick && pcnt_r == 10'h001 |-> h_len_r + 10'h001 == h_width_r;
    endproperty
    a_width: assert property (p_width) else $error("countdown pulse width wrong"); // R2 R3

    property p_zero_stop;
        !pulse_act && TIMER_EVENT && TIMER_N == 8'h00 |=> !pulse_act;
    endproperty
    a_zero_stop: assert property (p_zero_stop) else $error("pulse from zero count"); // R4

    property p_cut;
        pulse_act && !ctrl2_r.cdf |=> !pulse_act;
    endproperty
    a_cut: assert property (p_cut) else $error("pulse not cut by flag clear"); // R5

    property p_gate;
        (!ctrl2_r.timer_irq_enable && !ctrl2_r.alarm_irq_enable && !MS_IRQ) [*2] |-> INT_N;
    endproperty
    a_gate: assert property (p_gate) else $error("interrupt while disabled"); // R1 R6

    property p_alarm_release;
        s_alarm_cleared |=> INT_N;
    endproperty
    a_alarm_release: assert property (p_alarm_release) else $error("alarm clear did not release pin"); // R8

    property p_off_low;
        sqw_sel_r == 3'h7 && !ctrl1_r.external_clock_test |=> SQW_OE;
    endproperty
    a_off_low: assert property (p_off_low) else $error("disabled output not low"); // R9

    property p_freeze_low;
        s_frozen_slow [*2] |=> SQW_OE;
    endproperty
    a_freeze_low: assert property (p_freeze_low) else $error("slow output ran in freeze"); // R12

    property p_test_input;
        ctrl1_r.external_clock_test |=> !SQW_OE;
    endproperty
    a_test_input: assert property (p_test_input) else $error("pin driven in test mode"); // R13

    property p_tdiv_clear;
        ctrl1_r.freeze && $past(ctrl1_r.freeze) |=> tdiv_r == '0 && !SECOND_TICK [*1];
    endproperty
    a_tdiv_clear: assert property (p_tdiv_clear) else $error("test divider not held"); // R14

    property p_tick;
        !ctrl1_r.external_clock_test && $rose(pre_q[STAGES-1]) |=> SECOND_TICK;
    endproperty
    a_tick: assert property (p_tick) else $error("missed second on top stage rise"); // R20
endmodule

`default_nettype wire

// >>> host_side_model.sv
// host side of the block: oscillator source, pin pull-ups, test clock drive
// assumes every level is sampled on clk by the device
`timescale 1ns/1ps
`default_nettype none

module host_side_model #(
    parameter int OSC_HALF = 4
) (
    input  wire logic clk,
    input  wire logic sqw_oe,
    input  wire logic int_n,
    input  wire logic ext_en,
    input  wire logic ext_level,
    output logic      osc,
    output logic      sqw_pin,
    output logic      int_pin
);
    logic osc_r = 1'b0;
    int   osc_cnt_r = 0;

    ////////////////////////////////////////////////////////////////
    // oscillator, shortened so the run stays brief
    always_ff @(posedge clk)
    begin
        if (osc_cnt_r == OSC_HALF - 1)
        begin
            osc_cnt_r <= 0;
            osc_r     <= ~osc_r;
        end
        else
            osc_cnt_r <= osc_cnt_r + 1;
    end
    assign osc = osc_r;

    ////////////////////////////////////////////////////////////////
    // host drives pin only in test mode, pull-up otherwise
    assign sqw_pin = sqw_oe ? 1'b0 : (ext_en ? ext_level : 1'b1);
    assign int_pin = int_n ? 1'b1 : 1'b0;
endmodule

`default_nettype wire

// >>> tb.sv
// self-checking bench for the timekeeping support block
// assumes host_side_model supplies oscillator and pin levels
`timescale 1ns/1ps
`default_nettype none

module tb;
    import rtc_aux_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       reg_wr = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       timer_event = 1'b0;
    logic [7:0] timer_n = 8'h00;
    timer_src_t timer_src = SRC_4096;
    logic       alarm_event = 1'b0;
    logic       ms_irq = 1'b0;
    logic       ext_en = 1'b0;
    logic       ext_level = 1'b0;
    logic       osc;
    logic       sqw_i;
    logic       sqw_o;
    logic       sqw_oe;
    logic       int_n;
    logic       int_pin;
    logic       second_tick;
    int         errors = 0;
    int         samples_checked = 0;

    rtc_prescaler_square_wave_pin_irq u_rtc_prescaler_square_wave_pin_irq (
        .CLK(clk), .RST(rst), .OSC_IN(osc), .REG_WR(reg_wr), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .TIMER_EVENT(timer_event),
        .TIMER_N(timer_n), .TIMER_SRC(timer_src), .ALARM_EVENT(alarm_event),
        .MS_IRQ(ms_irq), .SQW_I(sqw_i), .SQW_O(sqw_o), .SQW_OE(sqw_oe),
        .INT_N(int_n), .SECOND_TICK(second_tick)
    );

    host_side_model u_host_side_model (
        .clk(clk), .sqw_oe(sqw_oe), .int_n(int_n), .ext_en(ext_en),
        .ext_level(ext_level), .osc(osc), .sqw_pin(sqw_i), .int_pin(int_pin)
    );

    initial
    begin
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        cyc(3);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        cyc(2);
        d = reg_rdata;
    endtask

    task automatic wait_int(input logic lvl, input int bound);
        int k;
        k = 0;
        while (int_pin !== lvl && k < bound)
        begin
            cyc(1);
            k++;
        end
        if (int_pin !== lvl)
        begin
            errors++;
            $display("[ERR] %0t interrupt pin wait ran out", $time);
            complete_run();
        end
    endtask

    task automatic pulse_event(input bit alarm);
        @(posedge clk);
        if (alarm)
            alarm_event <= 1'b1;
        else
            timer_event <= 1'b1;
        @(posedge clk);
        alarm_event <= 1'b0;
        timer_event <= 1'b0;
        #1;
    endtask

    task automatic sqw_measure(output int highs, output int rises, output int ticks);
        logic prev;
        highs = 0;
        rises = 0;
        ticks = 0;
        prev  = sqw_i;
        repeat (2048)
        begin
            cyc(1);
            highs += int'(sqw_i);
            rises += int'(sqw_i && !prev);
            ticks += int'(second_tick);
            prev = sqw_i;
        end
    endtask

    task automatic ext_pulses(input int n, output int ticks);
        ticks = 0;
        for (int i = 0; i < n * 8; i++)
        begin
            @(posedge clk);
            ext_level <= (i % 8) < 4;
            #1;
            ticks += int'(second_tick);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // power-on state
    task automatic t_reset();
        logic [7:0] d;
        check(int_pin, 1);
        check(sqw_o, 0);
        rd(4'h0, d);
        check(d, 8'h00);
        rd(4'h1, d);
        check(d, 8'h00);
        rd(4'hD, d);
        check(d, 8'h00);
        rd(4'h5, d);
        check(d, 8'h00);
    endtask

    // every code but 1 Hz, counted over whole periods
    task automatic t_sqw_freq();
        int h;
        int r;
        int t;
        for (int s = 0; s < 8; s++)
        begin
            if (s == 6)
                continue;
            wr(4'hD, 8'(s));
            cyc(8);
            sqw_measure(h, r, t);
            check(r, (s == 7) ? 0 : (2048 >> (3 + s)));
            if (s > 0)
                check(h, (s == 7) ? 0 : 1024);
        end
    endtask

    // freeze stops slow outputs and second ticks
    task automatic t_sqw_freeze();
        int sel_l[3] = '{1, 3, 6};
        int h;
        int r;
        int t;
        wr(4'h0, 8'h20);
        foreach (sel_l[i])
        begin
            wr(4'hD, 8'(sel_l[i]));
            cyc(8);
            sqw_measure(h, r, t);
            check(h, (sel_l[i] == 1) ? 1024 : 0);
            check(t, 0);
        end
        wr(4'h0, 8'h00);
        wr(4'hD, 8'h07);
    endtask

    // pulse widths per source and loaded value
    task automatic t_timer_pulse();
        int src_l[6] = '{0, 0, 1, 1, 2, 3};
        int n_l[6]   = '{1, 5, 1, 2, 3, 1};
        int tk_l[6]  = '{4, 8, 256, 512, 512, 512};
        int w;
        logic [7:0] d;
        for (int i = 0; i < 6; i++)
        begin
            wr(4'h1, 8'h11);
            @(posedge clk);
            timer_src <= timer_src_t'(src_l[i]);
            timer_n   <= 8'(n_l[i]);
            pulse_event(0);
            wait_int(0, 6);
            w = 0;
            while (int_pin === 1'b0 && w < 6000)
            begin
                cyc(1);
                w++;
            end
            check(w >= tk_l[i] * 8 - 10 && w <= tk_l[i] * 8 + 10, 1);
            rd(4'h1, d);
            check(d[2], 1);
            wr(4'h1, 8'h11);
            rd(4'h1, d);
            check(d[2], 0);
        end
    endtask

    // gating, zero value, early clear, level release
    task automatic t_timer_gate();
        logic [7:0] d;
        @(posedge clk);
        timer_src <= SRC_64;
        timer_n   <= 8'h00;
        wr(4'h1, 8'h11);
        pulse_event(0);
        cyc(20);
        check(int_pin, 1);
        rd(4'h1, d);
        check(d[2], 0);
        @(posedge clk);
        timer_n <= 8'h02;
        wr(4'h1, 8'h10);
        pulse_event(0);
        cyc(20);
        check(int_pin, 1);
        wr(4'h1, 8'h11);
        pulse_event(0);
        wait_int(0, 6);
        cyc(50);
        wr(4'h1, 8'h11);
        check(int_pin, 1);
        wr(4'h1, 8'h01);
        pulse_event(0);
        wait_int(0, 6);
        cyc(100);
        check(int_pin, 0);
        wr(4'h1, 8'h04);
        check(int_pin, 1);
        rd(4'h1, d);
        check(d[2], 1);
        wr(4'h1, 8'h00);
    endtask

    // alarm follows flag, second source joins the line
    task automatic t_alarm();
        pulse_event(1);
        cyc(10);
        check(int_pin, 1);
        wr(4'h1, 8'h0A);
        check(int_pin, 0);
        cyc(200);
        check(int_pin, 0);
        wr(4'h1, 8'h02);
        check(int_pin, 1);
        @(posedge clk);
        ms_irq <= 1'b1;
        cyc(3);
        check(int_pin, 0);
        @(posedge clk);
        ms_irq <= 1'b0;
        cyc(3);
        check(int_pin, 1);
    endtask

    task automatic t_test_mode();
        int t;
        @(posedge clk);
        ext_en <= 1'b1;
        wr(4'h0, 8'h80);
        check(sqw_oe, 0);
        wr(4'h0, 8'hA0);
        wr(4'h0, 8'h80);
        ext_pulses(31, t);
        check(t, 0);
        ext_pulses(1, t);
        check(t, 1);
        ext_pulses(63, t);
        check(t, 0);
        ext_pulses(1, t);
        check(t, 1);
        ext_pulses(10, t);
        wr(4'h0, 8'hA0);
        ext_pulses(40, t);
        check(t, 0);
        wr(4'h0, 8'h80);
        ext_pulses(31, t);
        check(t, 0);
        ext_pulses(1, t);
        check(t, 1);
        wr(4'h0, 8'h00);
        @(posedge clk);
        ext_en <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        t_reset();
        t_sqw_freq();
        t_sqw_freeze();
        t_timer_pulse();
        t_timer_gate();
        t_alarm();
        t_test_mode();
        complete_run();
    end
endmodule

`default_nettype wire
